// File: bdmd_pkg.sv
// constants and types for the banked data memory decoder
package bdmd_pkg;
  localparam int unsigned ADDR_W       = 12;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned BANK_W       = 4;
  localparam int unsigned LOC_W        = 8;
  localparam int unsigned SFR_OFS_W    = 7;
  localparam int unsigned SFR_COUNT    = 128;
  localparam int unsigned GPR_BANKS    = 6;
  localparam int unsigned GPR_BYTES    = GPR_BANKS * 256;
  localparam int unsigned GPR_IDX_W    = 11;

  localparam logic [ADDR_W-1:0] SFR_BASE      = 12'hF80;
  localparam logic [ADDR_W-1:0] SFR_TOP       = 12'hFFF;
  localparam logic [ADDR_W-1:0] GPR_LIMIT     = 12'h600;
  localparam logic [ADDR_W-1:0] BANK_SEL_ADDR = 12'hFE0;
  localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hF;
  localparam logic [BANK_W-1:0] ACCESS_LO_BANK = 4'h0;
  localparam int unsigned       ACCESS_SPLIT_BIT = 7;

  localparam logic [BANK_W-1:0] BANK_SEL_RST  = 4'h0;
  localparam logic [DATA_W-1:0] SFR_RST       = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO     = 8'h00;

  // indirect operand groups: five non-physical locations each, top one listed
  localparam logic [ADDR_W-1:0] IND0_TOP      = 12'hFEF;
  localparam logic [ADDR_W-1:0] IND1_TOP      = 12'hFE7;
  localparam logic [ADDR_W-1:0] IND2_TOP      = 12'hFDF;
  localparam logic [ADDR_W-1:0] IND_SPAN      = 12'h004;

  // one bit per sfr offset from SFR_BASE: 1 = implemented
  localparam logic [SFR_COUNT-1:0] SFR_IMPL_MASK =
    128'hFFFFFFFF_FFEFFFFE_FC07F807_E07C3E1F;
  // extra port direction, latch and pin registers absent on small variants
  localparam logic [SFR_COUNT-1:0] EXTRA_PORT_MASK =
    128'h00000000_00000000_00000000_00603018;

  typedef enum logic [1:0] {
    BDMD_PTR_0 = 2'h0,
    BDMD_PTR_1 = 2'h1,
    BDMD_PTR_2 = 2'h2,
    BDMD_PTR_NONE = 2'h3
  } bdmd_ptr_t;
endpackage

// File: bdmd_sfr_if.sv
// carrier between decoder and special function register store
`timescale 1ns/1ps
interface bdmd_sfr_if;
  logic [bdmd_pkg::SFR_OFS_W-1:0] ofs;
  logic                           wr;
  logic [bdmd_pkg::DATA_W-1:0]    wdata;
  logic [bdmd_pkg::DATA_W-1:0]    rdata;
  logic                           impl;
  modport dec   (output ofs, output wr, output wdata, input rdata, input impl);
  modport store (input ofs, input wr, input wdata, output rdata, output impl);
endinterface

// File: bdmd_sfr_store.sv
// special function register storage with implemented-location mask
`timescale 1ns/1ps
module bdmd_sfr_store #(
  parameter bit SMALL_VARIANT = 1'b0 // extra ports absent
) (
  input  wire logic      ref_clk, // core clock
  input  wire logic      rstn,    // async reset, active low
  bdmd_sfr_if.store      sfr      // access from decoder
);
  localparam logic [bdmd_pkg::SFR_COUNT-1:0] LIVE_MASK =
    SMALL_VARIANT ? (bdmd_pkg::SFR_IMPL_MASK & ~bdmd_pkg::EXTRA_PORT_MASK) : bdmd_pkg::SFR_IMPL_MASK;

  logic [bdmd_pkg::DATA_W-1:0] regs_q [bdmd_pkg::SFR_COUNT];
  wire                         hit_impl;

  // ============================================================
  // decode
  assign hit_impl  = LIVE_MASK[sfr.ofs];
  assign sfr.impl  = hit_impl;
  assign sfr.rdata = hit_impl ? regs_q[sfr.ofs] : bdmd_pkg::READ_ZERO;

  // ============================================================
  // storage
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < bdmd_pkg::SFR_COUNT; i++) begin
        regs_q[i] <= bdmd_pkg::SFR_RST;
      end
    end else if (sfr.wr && hit_impl) begin
      regs_q[sfr.ofs] <= sfr.wdata;
    end
  end
endmodule

// File: bdmd_decode.sv
// banked data memory decoder with general purpose ram and sfr region
`timescale 1ns/1ps
module bdmd_decode #(
  parameter bit SMALL_VARIANT = 1'b0 // extra ports absent
) (
  input  wire logic                           ref_clk,      // core clock, 10 MHz
  input  wire logic                           rstn,         // async reset, active low
  input  wire logic                           por_event,    // high when reset was power-on
  input  wire logic                           rd_en,        // read request
  input  wire logic                           wr_en,        // write request
  input  wire logic                           access_sel,   // instruction a bit
  input  wire logic [bdmd_pkg::LOC_W-1:0]     loc,          // instruction file field
  input  wire logic [bdmd_pkg::DATA_W-1:0]    wr_data,      // write byte
  input  wire logic [bdmd_pkg::ADDR_W-1:0]    ptr0_addr,    // file select pointer 0
  input  wire logic [bdmd_pkg::ADDR_W-1:0]    ptr1_addr,    // file select pointer 1
  input  wire logic [bdmd_pkg::ADDR_W-1:0]    ptr2_addr,    // file select pointer 2
  output logic      [bdmd_pkg::DATA_W-1:0]    rd_data_q,    // read byte
  output logic                                rd_valid_q,   // read answer pulse
  output logic      [bdmd_pkg::ADDR_W-1:0]    eff_addr_q,   // last resolved address
  output logic                                is_sfr_q,     // last access hit sfr area
  output logic                                is_unimpl_q,  // last access hit nothing
  output logic                                is_indirect_q,// last access was redirected
  output logic      [bdmd_pkg::BANK_W-1:0]    bank_sel_q    // bank selector value
);
  // ============================================================
  // functions
  // which pointer group, if any, an address falls in
  function automatic bdmd_pkg::bdmd_ptr_t ind_group(input logic [bdmd_pkg::ADDR_W-1:0] a);
    bdmd_pkg::bdmd_ptr_t g;
    g = bdmd_pkg::BDMD_PTR_NONE;
    if (a <= bdmd_pkg::IND0_TOP && a >= bdmd_pkg::IND0_TOP - bdmd_pkg::IND_SPAN) begin
      g = bdmd_pkg::BDMD_PTR_0;
    end else if (a <= bdmd_pkg::IND1_TOP && a >= bdmd_pkg::IND1_TOP - bdmd_pkg::IND_SPAN) begin
      g = bdmd_pkg::BDMD_PTR_1;
    end else if (a <= bdmd_pkg::IND2_TOP && a >= bdmd_pkg::IND2_TOP - bdmd_pkg::IND_SPAN) begin
      g = bdmd_pkg::BDMD_PTR_2;
    end
    return g;
  endfunction

  // ============================================================
  // declarations
  logic [bdmd_pkg::DATA_W-1:0] gpr_mem [bdmd_pkg::GPR_BYTES];

  wire  [bdmd_pkg::BANK_W-1:0]    bank_used;
  wire  [bdmd_pkg::ADDR_W-1:0]    direct_addr;
  wire  bdmd_pkg::bdmd_ptr_t      grp_direct;
  wire  bdmd_pkg::bdmd_ptr_t      grp_target;
  logic [bdmd_pkg::ADDR_W-1:0]    ptr_sel;
  wire  [bdmd_pkg::ADDR_W-1:0]    final_addr;
  wire                            redirected;
  wire                            nested_ind;
  wire                            hit_sfr;
  wire                            hit_gpr;
  wire                            hit_bank_sel;
  wire  [bdmd_pkg::GPR_IDX_W-1:0] gpr_idx;
  wire  [bdmd_pkg::GPR_IDX_W-1:0] gpr_rd_idx;
  wire  [bdmd_pkg::DATA_W-1:0]    gpr_rd;
  wire  [bdmd_pkg::DATA_W-1:0]    bank_rd;
  wire                            unimpl;
  wire  [bdmd_pkg::DATA_W-1:0]    rd_mux;
  wire                            gpr_wr;
  wire                            bank_wr;
  logic [bdmd_pkg::BANK_W-1:0]    bank_sel_d;
  wire                            status_we;
  wire  [bdmd_pkg::DATA_W-1:0]    rd_data_d;
  wire  [bdmd_pkg::ADDR_W-1:0]    eff_addr_d;
  wire                            is_sfr_d;
  wire                            is_unimpl_d;
  wire                            is_indirect_d;

  bdmd_sfr_if sfr ();

  // ============================================================
  // address formation
  // a bank selector write steers decode only from the following cycle
  assign bank_used = access_sel ? bank_sel_q
                   : (loc[bdmd_pkg::ACCESS_SPLIT_BIT] ? bdmd_pkg::ACCESS_HI_BANK
                                                       : bdmd_pkg::ACCESS_LO_BANK);
  assign direct_addr = {bank_used, loc};

  // ============================================================
  // indirect redirection
  // the pointer value is used as is, with no pre or post modify
  assign grp_direct = ind_group(direct_addr);
  assign redirected = (grp_direct != bdmd_pkg::BDMD_PTR_NONE);
  always_comb begin
    ptr_sel = direct_addr;
    unique case (grp_direct)
      bdmd_pkg::BDMD_PTR_0: begin
        ptr_sel = ptr0_addr;
      end
      bdmd_pkg::BDMD_PTR_1: begin
        ptr_sel = ptr1_addr;
      end
      bdmd_pkg::BDMD_PTR_2: begin
        ptr_sel = ptr2_addr;
      end
      bdmd_pkg::BDMD_PTR_NONE: begin
        ptr_sel = direct_addr;
      end
    endcase
  end
  assign final_addr = ptr_sel;
  // a pointer aimed at an indirect location has nothing behind it
  assign grp_target = ind_group(final_addr);
  assign nested_ind = (grp_target != bdmd_pkg::BDMD_PTR_NONE);

  // ============================================================
  // region decode
  assign hit_sfr      = (final_addr >= bdmd_pkg::SFR_BASE) && (final_addr <= bdmd_pkg::SFR_TOP);
  assign hit_gpr      = (final_addr < bdmd_pkg::GPR_LIMIT);
  assign hit_bank_sel = (final_addr == bdmd_pkg::BANK_SEL_ADDR);
  assign gpr_idx      = final_addr[bdmd_pkg::GPR_IDX_W-1:0];
  // only index the ram inside its populated range
  assign gpr_rd_idx   = hit_gpr ? gpr_idx : '0;
  assign gpr_rd       = gpr_mem[gpr_rd_idx];
  // upper bank selector bits are not stored and read back as zero
  assign bank_rd      = {{(bdmd_pkg::DATA_W-bdmd_pkg::BANK_W){1'b0}}, bank_sel_q};

  assign sfr.ofs   = final_addr[bdmd_pkg::SFR_OFS_W-1:0];
  // the bank selector is held here, not in the sfr store
  assign sfr.wr    = wr_en && hit_sfr && !hit_bank_sel && !nested_ind;
  assign sfr.wdata = wr_data;

  // dropped: unused sfrs, empty banks and pointers aimed at indirect slots
  assign unimpl = nested_ind || (!hit_gpr && !hit_sfr) || (hit_sfr && !sfr.impl);
  // a read and a write in one cycle return the byte held before the write
  assign rd_mux = unimpl       ? bdmd_pkg::READ_ZERO
                : hit_bank_sel ? bank_rd
                : hit_sfr      ? sfr.rdata
                : gpr_rd;

  // ============================================================
  // write strobes
  assign gpr_wr  = wr_en && hit_gpr;
  assign bank_wr = wr_en && hit_bank_sel && !nested_ind;
  assign bank_sel_d = bank_wr ? wr_data[bdmd_pkg::BANK_W-1:0] : bank_sel_q;

  // ============================================================
  // special function register store
  bdmd_sfr_store #(
    .SMALL_VARIANT (SMALL_VARIANT)
  ) u_sfr_store (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .sfr     (sfr.store)
  );

  // ============================================================
  // general purpose ram: no reset, contents survive every reset
  always_ff @(posedge ref_clk) begin
    if (gpr_wr) begin
      gpr_mem[gpr_idx] <= wr_data;
    end
  end

  // ============================================================
  // bank selector
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bank_sel_q <= bdmd_pkg::BANK_SEL_RST;
    end else begin
      bank_sel_q <= bank_sel_d;
    end
  end

  // ============================================================
  // read answer and status next values
  assign status_we     = rd_en || wr_en;
  assign rd_data_d     = rd_en ? rd_mux : rd_data_q;
  // status also follows writes, so a dropped write can be seen
  assign eff_addr_d    = status_we ? final_addr : eff_addr_q;
  assign is_sfr_d      = status_we ? hit_sfr : is_sfr_q;
  assign is_unimpl_d   = status_we ? unimpl : is_unimpl_q;
  assign is_indirect_d = status_we ? redirected : is_indirect_q;

  // ============================================================
  // read answer
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rd_valid_q <= 1'b0;
      rd_data_q  <= bdmd_pkg::READ_ZERO;
    end else begin
      rd_valid_q <= rd_en;
      rd_data_q  <= rd_data_d;
    end
  end

  // ============================================================
  // status of the last access
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      eff_addr_q    <= '0;
      is_sfr_q      <= 1'b0;
      is_unimpl_q   <= 1'b0;
      is_indirect_q <= 1'b0;
    end else begin
      eff_addr_q    <= eff_addr_d;
      is_sfr_q      <= is_sfr_d;
      is_unimpl_q   <= is_unimpl_d;
      is_indirect_q <= is_indirect_d;
    end
  end

  // por_event drives nothing in this decoder; ram is untouched either way
  wire unused_por = por_event;
endmodule

// File: bdmd_checker.sv
// concurrent checks on the decoder top ports
`timescale 1ns/1ps
module bdmd_checker (
  input wire logic        ref_clk,       // core clock
  input wire logic        rstn,          // async reset, active low
  input wire logic        rd_en,         // read request
  input wire logic        wr_en,         // write request
  input wire logic        access_sel,    // access bank select
  input wire logic [7:0]  loc,           // file field
  input wire logic [7:0]  wr_data,       // write byte
  input wire logic [11:0] ptr0_addr,     // pointer 0
  input wire logic [7:0]  rd_data_q,     // read byte
  input wire logic        rd_valid_q,    // read answer
  input wire logic [11:0] eff_addr_q,    // resolved address
  input wire logic        is_sfr_q,      // sfr hit
  input wire logic        is_unimpl_q,   // nothing hit
  input wire logic        is_indirect_q, // redirected
  input wire logic [3:0]  bank_sel_q     // bank selector
);
  // ====
  // properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire ind_loc = loc inside {[8'hDB:8'hDF], [8'hE3:8'hE7], [8'hEB:8'hEF]};
  sequence req_s;
    rd_en || wr_en;
  endsequence
  rd_answer_a: assert property (rd_en |=> rd_valid_q) else $error("read not answered");
  acc_low_a: assert property (req_s ##0 (!access_sel && !loc[7])
    |=> eff_addr_q == {4'h0, $past(loc)} && !is_sfr_q) else $error("access low wrong");
  acc_high_a: assert property (req_s ##0 (!access_sel && loc[7] && !ind_loc)
    |=> is_sfr_q && eff_addr_q == {4'hF, $past(loc)}) else $error("access high wrong");
  banked_a: assert property (req_s ##0 (access_sel && !(bank_sel_q == 4'hF && ind_loc))
    |=> eff_addr_q == {$past(bank_sel_q), $past(loc)}) else $error("banked address wrong");
  gpr_hit_a: assert property (req_s ##0 (access_sel && bank_sel_q < 4'h6)
    |=> !is_unimpl_q && !is_sfr_q) else $error("ram bank not hit");
  unpop_bank_a: assert property (req_s ##0 (access_sel && bank_sel_q inside {[4'h6:4'hE]})
    |=> is_unimpl_q) else $error("empty bank not flagged");
  zero_read_a: assert property (rd_valid_q && is_unimpl_q |-> rd_data_q == 8'h00)
    else $error("unimplemented read not zero");
  bank_write_a: assert property (wr_en && !access_sel && loc == 8'hE0
    |=> bank_sel_q == $past(wr_data[3:0])) else $error("bank selector not written");
  indirect_a: assert property (req_s ##0 (!access_sel && loc == 8'hEF && ptr0_addr < 12'hF00)
    |=> is_indirect_q && eff_addr_q == $past(ptr0_addr)) else $error("redirect wrong");
endmodule
bind bdmd_decode bdmd_checker chk (.ref_clk, .rstn, .rd_en, .wr_en, .access_sel, .loc, .wr_data, .ptr0_addr,
  .rd_data_q, .rd_valid_q, .eff_addr_q, .is_sfr_q, .is_unimpl_q, .is_indirect_q, .bank_sel_q);

// File: bdmd_cpu_model.sv
// cpu datapath model issuing data memory accesses
`timescale 1ns/1ps
module bdmd_cpu_model (
  input  wire logic  ref_clk,    // core clock
  output logic       rd_en,      // read request
  output logic       wr_en,      // write request
  output logic       access_sel, // access bank select
  output logic [7:0] loc,        // file field
  output logic [7:0] wr_data,    // write byte
  output logic [11:0] ptr0_addr, // pointer 0
  output logic [11:0] ptr1_addr, // pointer 1
  output logic [11:0] ptr2_addr  // pointer 2
);
  // ====
  // idle state and access task
  initial begin
    {rd_en, wr_en, access_sel, loc, wr_data} = '0;
    {ptr0_addr, ptr1_addr, ptr2_addr} = {12'h123, 12'h234, 12'h345};
  end
  // held over one rising edge, then fields scrambled so stale values never match
  task automatic acc(input logic r, input logic w, input logic a, input logic [7:0] l, input logic [7:0] d);
    @(negedge ref_clk);
    {rd_en, wr_en, access_sel, loc, wr_data} = {r, w, a, l, d};
    @(negedge ref_clk);
    {rd_en, wr_en} = 2'h0;
    loc = ~l;
    wr_data = ~d;
  endtask
  // retarget pointer 0 between accesses
  task automatic set_ptr0(input logic [11:0] p);
    @(negedge ref_clk);
    ptr0_addr = p;
  endtask
endmodule

// File: tb_banked_data_memory_decode.sv
// self-checking bench for the banked data memory decoder
`timescale 1ns/1ps
module tb_banked_data_memory_decode;
  logic        ref_clk, rstn, por_event, rd_en, wr_en, access_sel;
  logic        rd_valid_q, is_sfr_q, is_unimpl_q, is_indirect_q;
  logic [7:0]  loc, wr_data, rd_data_q;
  logic [11:0] ptr0_addr, ptr1_addr, ptr2_addr, eff_addr_q;
  logic [3:0]  bank_sel_q;
  logic [7:0]  small_rd_data_q;
  logic        small_is_unimpl_q;
  int          num_errors = 0;
  int          compares = 0;
  bdmd_cpu_model cpu (.ref_clk, .rd_en, .wr_en, .access_sel, .loc, .wr_data, .ptr0_addr, .ptr1_addr, .ptr2_addr);
  bdmd_decode uut (.ref_clk, .rstn, .por_event, .rd_en, .wr_en, .access_sel, .loc, .wr_data, .ptr0_addr,
    .ptr1_addr, .ptr2_addr, .rd_data_q, .rd_valid_q, .eff_addr_q, .is_sfr_q, .is_unimpl_q, .is_indirect_q,
    .bank_sel_q);
  bdmd_decode #(.SMALL_VARIANT(1'b1)) uut_small (.ref_clk, .rstn, .por_event, .rd_en, .wr_en, .access_sel,
    .loc, .wr_data, .ptr0_addr, .ptr1_addr, .ptr2_addr, .rd_data_q(small_rd_data_q), .rd_valid_q(),
    .eff_addr_q(), .is_sfr_q(), .is_unimpl_q(small_is_unimpl_q), .is_indirect_q(), .bank_sel_q());
  // ====
  // helpers
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkf(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic a, input logic [7:0] l, input logic [7:0] d);
    cpu.acc(1'b0, 1'b1, a, l, d);
  endtask
  task automatic rd(input logic a, input logic [7:0] l);
    cpu.acc(1'b1, 1'b0, a, l, 8'h00);
    chkf(rd_valid_q, 1'b1);
  endtask
  task automatic report_and_stop;
    if (num_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ====
  // scenarios
  task automatic t_banks;
    for (int b = 0; b < 6; b++) begin
      wr(1'b0, 8'hE0, 8'(b));
      wr(1'b1, 8'h3C, 8'(8'hA0 + b));
    end
    for (int b = 0; b < 6; b++) begin
      wr(1'b0, 8'hE0, 8'(b));
      rd(1'b1, 8'h3C);
      chk({4'h0, rd_data_q}, 12'(8'hA0 + b));
      chk(eff_addr_q, {4'(b), 8'h3C});
    end
    for (int i = 0; i < 2; i++) begin
      wr(1'b0, 8'hE0, {4'h0, i ? 4'hE : 4'h6});
      wr(1'b1, 8'h3C, 8'h55);
      rd(1'b1, 8'h3C);
      chk({4'h0, rd_data_q}, 12'h000);
      chkf(is_unimpl_q, 1'b1);
    end
  endtask
  task automatic t_access;
    wr(1'b0, 8'hE0, 8'h03);
    wr(1'b0, 8'h05, 8'h77);
    wr(1'b0, 8'hE0, 8'h00);
    rd(1'b1, 8'h05);
    chk({4'h0, rd_data_q}, 12'h077);
    chkf(is_sfr_q, 1'b0);
    wr(1'b0, 8'hD5, 8'h5A);
    wr(1'b0, 8'hE0, 8'hFF);
    chk({8'h00, bank_sel_q}, 12'h00F);
    rd(1'b1, 8'hD5);
    chk({4'h0, rd_data_q}, 12'h05A);
    chkf(is_sfr_q, 1'b1);
    rd(1'b0, 8'hE0);
    chk({4'h0, rd_data_q}, 12'h00F);
    wr(1'b0, 8'hD4, 8'hFF);
    rd(1'b0, 8'hD4);
    chk({4'h0, rd_data_q}, 12'h000);
  endtask
  task automatic t_indirect;
    wr(1'b0, 8'hEF, 8'h99);
    chkf(is_indirect_q, 1'b1);
    wr(1'b0, 8'hE0, 8'h01);
    rd(1'b1, 8'h23);
    chk({4'h0, rd_data_q}, 12'h099);
    chkf(is_indirect_q, 1'b0);
    rd(1'b0, 8'hE7);
    chk(eff_addr_q, 12'h234);
    rd(1'b0, 8'hDF);
    chk(eff_addr_q, 12'h345);
    cpu.set_ptr0(12'hFE7);
    wr(1'b0, 8'hEF, 8'h55);
    rd(1'b0, 8'hEF);
    chk({4'h0, rd_data_q}, 12'h000);
    chkf(is_unimpl_q, 1'b1);
  endtask
  task automatic t_variant;
    wr(1'b0, 8'h83, 8'hC3);
    rd(1'b0, 8'h83);
    chk({4'h0, rd_data_q}, 12'h0C3);
    chkf(is_unimpl_q, 1'b0);
    chk({4'h0, small_rd_data_q}, 12'h000);
    chkf(small_is_unimpl_q, 1'b1);
  endtask
  task automatic t_reset;
    wr(1'b0, 8'h10, 8'h3E);
    rstn = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk({8'h00, bank_sel_q}, 12'h000);
    rstn = 1'b1;
    rd(1'b0, 8'h10);
    chk({4'h0, rd_data_q}, 12'h03E);
  endtask
  // ====
  // clock, reset and sequence
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    #5000000;
    num_errors++;
    report_and_stop;
  end
  initial begin
    rstn = 1'b0;
    por_event = 1'b1;
    repeat (12) @(negedge ref_clk);
    rstn = 1'b1;
    por_event = 1'b0;
    t_banks;
    t_access;
    t_indirect;
    t_variant;
    t_reset;
    report_and_stop;
  end
endmodule
